// ---- include/uart_cfg.svh ----
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
// register byte offsets on the bus
`define OFF_DATA        8'h00
`define OFF_STAT_A      8'h04
`define OFF_STAT_B      8'h08
`define OFF_STAT_C      8'h0C
`define OFF_BAUD        8'h10
// ctrl_status_a fields
`define A_RX_DONE       7
`define A_TX_DONE       6
`define A_TX_EMPTY      5
`define A_FRAME_ERR     4
`define A_OVERRUN       3
`define A_PAR_ERR       2
// ctrl_status_b fields
`define B_TX_DONE_IE    6
`define B_TX_EMPTY_IE   5
`define B_RX_ON         4
`define B_TX_ON         3
`define B_RX_NINTH      1
`define B_TX_NINTH      0
// ctrl_status_c fields
`define C_SYNC          6
`define C_PAR_EN        5
`define C_PAR_ODD       4
`define C_TWO_STOP      3
`define C_SIZE_HI       2
`define C_SIZE_LO       0
`define SIZE_NINE       3'h7
`define C_RST           7'h06
`define BAUD_RST        16'h0000
`define AXI_OKAY        2'h0
`define AXI_SLVERR      2'h2
`endif

// ---- include/uart_pkg.sv ----
package uart_pkg;
  // one received frame as stored in the receive fifo
  typedef struct packed {
    logic       frame_err;
    logic       overrun;
    logic       par_err;
    logic       ninth;
    logic [7:0] data;
  } rx_entry_t;
  // frame format shared by both directions
  typedef struct packed {
    logic       par_en;
    logic       par_odd;
    logic       two_stop;
    logic [2:0] size;
  } frame_fmt_t;
endpackage

// ---- core/uart_tx_shift.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "uart_cfg.svh"
module uart_tx_shift
  import uart_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       bit_tick_i,
  input  wire frame_fmt_t fmt_i,
  input  wire logic       load_i,
  input  wire logic [8:0] char_i,
  output logic            busy_o,
  output logic            last_o,
  output logic            txd_o
);
  logic [12:0] frame_reg;
  logic [3:0]  left_reg;
  logic [3:0]  nbits;
  logic        par;
  logic [8:0]  masked;

  // data bits from the size field; 7 means nine bits
  always_comb begin
    case (fmt_i.size)
      3'h0:    nbits = 4'h5;
      3'h1:    nbits = 4'h6;
      3'h2:    nbits = 4'h7;
      3'h7:    nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
    masked = char_i & ~(9'h1FF << nbits);
    par    = ^masked ^ fmt_i.par_odd;
  end

  // frame built lsb first: start, data, parity, stops
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      frame_reg <= 13'h1FFF;
      left_reg  <= 4'h0;
      txd_o     <= 1'b1;
    end else if (load_i) begin
      frame_reg <= (13'h1FFF << (nbits + 4'h1 + {3'h0, fmt_i.par_en}))
                 | {2'h0, fmt_i.par_en & par, 10'h000} >> (4'h9 - nbits)
                 | {3'h0, masked, 1'b0};
      left_reg  <= nbits + 4'h2 + {3'h0, fmt_i.par_en}
                 + {3'h0, fmt_i.two_stop};
      // a load on the last tick must still put the stop level on the line
      if (bit_tick_i) begin
        txd_o <= 1'b1;
      end
    end else if (bit_tick_i && left_reg != 4'h0) begin
      txd_o     <= frame_reg[0];
      frame_reg <= {1'b1, frame_reg[12:1]};
      left_reg  <= left_reg - 4'h1;
    end else if (bit_tick_i) begin
      txd_o     <= 1'b1; // idle high
    end
  end

  assign busy_o = (left_reg != 4'h0);
  // last stop bit goes out on this tick
  assign last_o = bit_tick_i && left_reg == 4'h1;
endmodule
`default_nettype wire

// ---- core/uart_rx_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module uart_rx_fifo
  import uart_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic      clock_i,
  input  wire logic      reset_i,
  input  wire logic      flush_i,
  input  wire logic      push_i,
  input  wire rx_entry_t wdata_i,
  input  wire logic      pop_i,
  output rx_entry_t      rdata_o,
  output logic           full_o,
  output logic           empty_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  rx_entry_t   mem [DEPTH];
  logic [AW:0] cnt_reg;
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] wr_reg;
  logic        do_push;
  logic        do_pop;

  assign full_o  = (cnt_reg == (AW+1)'(DEPTH));
  assign empty_o = (cnt_reg == '0);
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;
  assign rdata_o = mem[rd_reg];

  // storage; entries need no reset, count guards them
  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem[wr_reg] <= wdata_i;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge clock_i) begin
    if (reset_i || flush_i) begin
      cnt_reg <= '0;
      rd_reg  <= '0;
      wr_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule
`default_nettype wire

// ---- core/uart_core.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "uart_cfg.svh"
module uart_core
  import uart_pkg::*;
#(
  parameter int RX_DEPTH = 2
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt side
  input  wire logic        global_irq_en_i,
  input  wire logic        tx_done_ack_i,
  output logic             tx_empty_irq_o,
  output logic             tx_done_irq_o,
  // line
  input  wire logic        serial_in_pin_i,
  input  wire logic        ext_transfer_clock_i,
  output logic             serial_out_pin_o,
  output logic             serial_out_oe_o,
  output logic             rx_pin_owned_o
);
  frame_fmt_t  fmt;
  rx_entry_t   rx_head;
  rx_entry_t   rx_new;
  logic [15:0] baud_reg;
  logic [15:0] div_reg;
  logic [6:0]  stat_c_reg;
  logic [8:0]  hold_reg;
  logic        hold_full_reg;
  logic        tx_ninth_reg;
  logic        tx_done_flag;
  logic        tx_empty_irq_en;
  logic        tx_done_irq_en;
  logic        transmit_on;
  logic        tx_active_reg;
  logic        receive_on;
  logic        bit_tick;
  logic        xck_q_reg;
  logic        tx_busy;
  logic        tx_last;
  logic        txd;
  logic        tx_load;
  logic        rx_full;
  logic        rx_empty;
  logic        rx_push;
  logic        rx_pop;
  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  aw_reg;
  logic [31:0] wd_reg;
  logic [3:0]  ws_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [3:0]  rx_cnt_reg;
  logic [8:0]  rx_sh_reg;
  logic        rx_par_reg;
  logic        rx_busy_reg;
  logic        ovr_pend_reg;
  logic [3:0]  nbits;
  logic        rxd;

  assign fmt = '{par_en:   stat_c_reg[`C_PAR_EN],
                 par_odd:  stat_c_reg[`C_PAR_ODD],
                 two_stop: stat_c_reg[`C_TWO_STOP],
                 size:     stat_c_reg[`C_SIZE_HI:`C_SIZE_LO]};
  assign nbits = (fmt.size == `SIZE_NINE) ? 4'h9 :
                 (fmt.size[2] ? 4'h8 : 4'h5 + {2'h0, fmt.size[1:0]});

  // bit rate: divider in async, rising edge of xck in sync mode
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      div_reg   <= `BAUD_RST;
      xck_q_reg <= 1'b0;
    end else begin
      div_reg   <= (div_reg == '0) ? baud_reg : div_reg - 16'h1;
      xck_q_reg <= ext_transfer_clock_i;
    end
  end
  assign bit_tick = stat_c_reg[`C_SYNC] ?
                    (ext_transfer_clock_i && !xck_q_reg) :
                    (div_reg == '0);

  // ---------------- axi4-lite write side
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign wr_fire = aw_have_reg && w_have_reg;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      aw_reg       <= '0;
      wd_reg       <= '0;
      ws_reg       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_reg      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wd_reg     <= s_axi_wdata;
        ws_reg     <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_reg > `OFF_BAUD) ? `AXI_SLVERR : `AXI_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; only the low byte lane matters except baud
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      stat_c_reg      <= `C_RST;
      baud_reg        <= `BAUD_RST;
      tx_empty_irq_en <= 1'b0;
      tx_done_irq_en  <= 1'b0;
      transmit_on     <= 1'b0;
      receive_on      <= 1'b0;
      tx_ninth_reg    <= 1'b0;
    end else if (wr_fire && ws_reg[0]) begin
      case (aw_reg)
        `OFF_STAT_B: begin
          tx_done_irq_en  <= wd_reg[`B_TX_DONE_IE];
          tx_empty_irq_en <= wd_reg[`B_TX_EMPTY_IE];
          receive_on      <= wd_reg[`B_RX_ON];
          transmit_on     <= wd_reg[`B_TX_ON];
          tx_ninth_reg    <= wd_reg[`B_TX_NINTH];
        end
        `OFF_STAT_C: stat_c_reg <= wd_reg[6:0];
        `OFF_BAUD:   baud_reg <= {ws_reg[1] ? wd_reg[15:8] : baud_reg[15:8],
                                  wd_reg[7:0]};
        default: ;
      endcase
    end
  end

  // ---------------- transmit path
  // holding buffer: cpu fills it, shifter drains it
  assign tx_load = hold_full_reg && tx_active_reg &&
                   (!tx_busy || tx_last);
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      hold_full_reg <= 1'b0;
      hold_reg      <= '0;
    end else if (wr_fire && ws_reg[0] && aw_reg == `OFF_DATA
                 && transmit_on) begin
      hold_full_reg <= 1'b1;
      hold_reg      <= {tx_ninth_reg, wd_reg[7:0]};
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;
    end
  end

  // turning off waits for both stages to drain
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_active_reg <= 1'b0;
    end else if (transmit_on) begin
      tx_active_reg <= 1'b1;
    end else if (!tx_busy && !hold_full_reg) begin
      tx_active_reg <= 1'b0;
    end
  end

  // done flag: set wins over either clear
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_done_flag <= 1'b0;
    end else if (tx_last && !hold_full_reg) begin
      tx_done_flag <= 1'b1;
    end else if (tx_done_ack_i || (wr_fire && ws_reg[0] &&
                 aw_reg == `OFF_STAT_A && wd_reg[`A_TX_DONE])) begin
      tx_done_flag <= 1'b0;
    end
  end

  // level requests; empty irq repeats until data or disable
  assign tx_empty_irq_o = global_irq_en_i && tx_empty_irq_en
                          && !hold_full_reg;
  assign tx_done_irq_o  = global_irq_en_i && tx_done_irq_en
                          && tx_done_flag;
  assign serial_out_pin_o = txd;
  assign serial_out_oe_o  = tx_active_reg;

  uart_tx_shift u_tx (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .bit_tick_i(bit_tick),
    .fmt_i     (fmt),
    .load_i    (tx_load),
    .char_i    (hold_reg),
    .busy_o    (tx_busy),
    .last_o    (tx_last),
    .txd_o     (txd)
  );

  // ---------------- receive path
  // one sample per bit tick; recovery filtering lives elsewhere
  assign rxd = receive_on ? serial_in_pin_i : 1'b1;
  assign rx_pin_owned_o = receive_on;
  assign rx_push = rx_busy_reg && bit_tick &&
                   rx_cnt_reg == nbits + {3'h0, fmt.par_en};
  always_ff @(posedge clock_i) begin
    if (reset_i || !receive_on) begin
      rx_busy_reg  <= 1'b0;
      rx_cnt_reg   <= '0;
      rx_sh_reg    <= '0;
      rx_par_reg   <= 1'b0;
      ovr_pend_reg <= 1'b0;
    end else if (bit_tick) begin
      if (!rx_busy_reg && !rxd) begin
        rx_busy_reg <= 1'b1; // start seen
        rx_cnt_reg  <= '0;
        rx_sh_reg   <= '0;
        if (rx_full) begin
          ovr_pend_reg <= 1'b1; // frame is lost if the fifo is still full at its end
        end
      end else if (rx_push) begin
        rx_busy_reg  <= 1'b0;
        if (!rx_full) begin
          ovr_pend_reg <= 1'b0;
        end
      end else if (rx_busy_reg) begin
        if (rx_cnt_reg < nbits) begin
          rx_sh_reg[rx_cnt_reg] <= rxd;
        end else begin
          rx_par_reg <= rxd;
        end
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
    end
  end
  assign rx_new = '{frame_err: !rxd,
                    overrun:   ovr_pend_reg,
                    par_err:   fmt.par_en && (rx_par_reg !=
                               (^rx_sh_reg ^ fmt.par_odd)),
                    ninth:     rx_sh_reg[8],
                    data:      rx_sh_reg[7:0]};

  uart_rx_fifo #(.DEPTH(RX_DEPTH)) u_rxf (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .flush_i(!receive_on),
    .push_i (rx_push),
    .wdata_i(rx_new),
    .pop_i  (rx_pop),
    .rdata_o(rx_head),
    .full_o (rx_full),
    .empty_o(rx_empty)
  );

  // ---------------- axi4-lite read side
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rx_pop  = rd_fire && s_axi_araddr == `OFF_DATA;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `AXI_OKAY;
      s_axi_rdata  <= '0;
      case (s_axi_araddr)
        `OFF_DATA: s_axi_rdata[7:0] <= rx_empty ? 8'h00 : rx_head.data;
        `OFF_STAT_A: begin
          s_axi_rdata[`A_RX_DONE]   <= !rx_empty;
          s_axi_rdata[`A_TX_DONE]   <= tx_done_flag;
          s_axi_rdata[`A_TX_EMPTY]  <= !hold_full_reg;
          s_axi_rdata[`A_FRAME_ERR] <= !rx_empty && rx_head.frame_err;
          s_axi_rdata[`A_OVERRUN]   <= !rx_empty && rx_head.overrun;
          s_axi_rdata[`A_PAR_ERR]   <= !rx_empty && rx_head.par_err;
        end
        `OFF_STAT_B: begin
          s_axi_rdata[`B_TX_DONE_IE]  <= tx_done_irq_en;
          s_axi_rdata[`B_TX_EMPTY_IE] <= tx_empty_irq_en;
          s_axi_rdata[`B_RX_ON]       <= receive_on;
          s_axi_rdata[`B_TX_ON]       <= transmit_on;
          s_axi_rdata[`B_RX_NINTH]    <= !rx_empty && rx_head.ninth;
          s_axi_rdata[`B_TX_NINTH]    <= tx_ninth_reg;
        end
        `OFF_STAT_C: s_axi_rdata[6:0]  <= stat_c_reg;
        `OFF_BAUD:   s_axi_rdata[15:0] <= baud_reg;
        default:     s_axi_rresp <= `AXI_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- checks
  AST_EMPTY_CLEAR: assert property (@(posedge clock_i) disable iff (reset_i)
    (wr_fire && ws_reg[0] && aw_reg == `OFF_DATA && transmit_on)
    |=> hold_full_reg) else $error("write did not fill buffer");
  AST_EMPTY_IRQ: assert property (@(posedge clock_i) disable iff (reset_i)
    (global_irq_en_i && tx_empty_irq_en && !hold_full_reg)
    |-> tx_empty_irq_o) else $error("empty irq missing");
  AST_DONE_SET: assert property (@(posedge clock_i) disable iff (reset_i)
    (tx_last && !hold_full_reg) |=> tx_done_flag)
    else $error("done flag not set");
  AST_DONE_ACK: assert property (@(posedge clock_i) disable iff (reset_i)
    (tx_done_ack_i && !tx_last) |=> !tx_done_flag)
    else $error("done flag not cleared");
  AST_DONE_IRQ: assert property (@(posedge clock_i) disable iff (reset_i)
    (tx_done_irq_en && global_irq_en_i && $rose(tx_done_flag))
    |-> tx_done_irq_o) else $error("done irq missing");
  AST_TX_OFF: assert property (@(posedge clock_i) disable iff (reset_i)
    (tx_busy || hold_full_reg) && tx_active_reg |=> tx_active_reg)
    else $error("tx released early");
  AST_RX_FLAG: assert property (@(posedge clock_i) disable iff (reset_i)
    (rx_push && receive_on && rx_empty) |=> !rx_empty)
    else $error("frame not stored");
  AST_RX_FLUSH: assert property (@(posedge clock_i) disable iff (reset_i)
    !receive_on |=> rx_empty) else $error("fifo not flushed");
  AST_LOAD_IDLE: assert property (@(posedge clock_i) disable iff (reset_i)
    (hold_full_reg && tx_active_reg && !tx_busy) |=> !hold_full_reg ||
    tx_busy) else $error("idle shifter not loaded");
endmodule
`default_nettype wire

// ---- verification/serial_node.sv ----
`timescale 1ns/100ps
`default_nettype none
// far-end node; its transfer clock only moves while a frame is moving
module serial_node (
  input  wire logic clock_i,
  input  wire logic line_from_dut_i,
  output logic      line_to_dut_o,
  output logic      xfer_clock_o
);
  logic [31:0] seen;
  // line idles high (pull-up), transfer clock parked low
  initial begin
    line_to_dut_o = 1'b1;
    xfer_clock_o  = 1'b0;
  end
  // bit i set up well ahead of its rising clock; dut line sampled first
  task automatic run(input logic [31:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line_to_dut_o <= bits[i];
      repeat (3) @(posedge clock_i);
      seen[i] = line_from_dut_i;
      xfer_clock_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      xfer_clock_o <= 1'b0;
      @(posedge clock_i);
    end
    line_to_dut_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- verification/uart_tx_rx_flags_datapath_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "uart_cfg.svh"
module uart_tx_rx_flags_datapath_tb;
  logic        clock_i, reset_i, global_irq_en_i, tx_done_ack_i;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, tx_empty_irq_o, tx_done_irq_o;
  logic        serial_in_pin_i, ext_transfer_clock_i, serial_out_pin_o;
  logic        serial_out_oe_o, rx_pin_owned_o;
  int          n_fail, total_checks, nx;

  uart_core #(.RX_DEPTH(2)) dut (.clock_i, .reset_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .global_irq_en_i, .tx_done_ack_i, .tx_empty_irq_o, .tx_done_irq_o,
    .serial_in_pin_i, .ext_transfer_clock_i, .serial_out_pin_o,
    .serial_out_oe_o, .rx_pin_owned_o);
  serial_node node (.clock_i(clock_i), .line_from_dut_i(serial_out_pin_o),
    .line_to_dut_o(serial_in_pin_i), .xfer_clock_o(ext_transfer_clock_i));

  // 40 MHz
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // aw and w offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    int   t;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok) && t < 200) begin
      @(posedge clock_i);
      t++;
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock_i); while (s_axi_bvalid !== 1'b1 && ++t < 400);
    s_axi_bready <= 1'b0;
    last_resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock_i); while (s_axi_arready !== 1'b1 && ++t < 200);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock_i); while (s_axi_rvalid !== 1'b1 && ++t < 400);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
  endtask

  // find a start bit at or after from; a follow-on frame must start at from
  task automatic fchk(input int from, input logic [11:0] exp, input int n,
                      output int nxt);
    int          s;
    logic [11:0] got;
    s = from;
    got = '0;
    while (s < 31 && node.seen[s] !== 1'b0) s++;
    for (int i = 0; i < n; i++) got[i] = node.seen[s+i];
    if (from > 0) chk(32'(s), 32'(from));
    chk(32'(got), 32'(exp));
    nxt = s + n;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, well beyond the thousand or so cycles the tests need
  initial begin
    #(25 * 20000);
    n_fail++;
    end_of_test();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, tx_done_ack_i} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    global_irq_en_i = 1'b1;
    n_fail = 0;
    total_checks = 0;
    reset_i = 1'b1;
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rd(`OFF_STAT_A, rv);
    chk(rv, 32'h0000_0020);
    rd(`OFF_STAT_C, rv);
    chk(rv, 32'h0000_0006);
    rd(8'h14, rv);
    chk(rv, 32'h0000_0000);
    chk(32'(last_resp), 32'(`AXI_SLVERR));
    $display("register test done");
    // back-to-back frames, sync mode, 8 bits
    wr(`OFF_STAT_C, 32'h0000_0046);
    wr(`OFF_STAT_B, 32'h0000_0078);
    chk(32'(tx_empty_irq_o), 32'h0000_0001);
    wr(`OFF_DATA, 32'h0000_00A5);
    wr(`OFF_DATA, 32'h0000_003C);
    rd(`OFF_STAT_A, rv);
    chk(rv & 32'h0000_0060, 32'h0000_0000);
    chk(32'(tx_empty_irq_o), 32'h0000_0000);
    node.run('1, 26);
    fchk(0, {1'b1, 8'hA5, 1'b0}, 10, nx);
    fchk(nx, {1'b1, 8'h3C, 1'b0}, 10, nx);
    rd(`OFF_STAT_A, rv);
    chk(rv & 32'h0000_0060, 32'h0000_0060);
    chk(32'(tx_done_irq_o), 32'h0000_0001);
    global_irq_en_i <= 1'b0;
    @(posedge clock_i);
    chk(32'(tx_done_irq_o | tx_empty_irq_o), 32'h0000_0000);
    global_irq_en_i <= 1'b1;
    wr(`OFF_STAT_A, 32'h0000_0040);
    rd(`OFF_STAT_A, rv);
    chk(rv & 32'h0000_0040, 32'h0000_0000);
    $display("transmit flags test done");
    // odd parity, transmitter switched off while the frame is pending
    wr(`OFF_STAT_C, 32'h0000_0076);
    wr(`OFF_DATA, 32'h0000_005A);
    wr(`OFF_STAT_B, 32'h0000_0070);
    chk(32'(serial_out_oe_o), 32'h0000_0001);
    node.run('1, 14);
    fchk(0, {1'b1, 1'b1, 8'h5A, 1'b0}, 11, nx);
    chk(32'(serial_out_oe_o), 32'h0000_0000);
    tx_done_ack_i <= 1'b1;
    @(posedge clock_i);
    tx_done_ack_i <= 1'b0;
    rd(`OFF_STAT_A, rv);
    chk(rv & 32'h0000_0040, 32'h0000_0000);
    $display("parity and disable test done");
    // two stops configured, second frame follows one stop, bad stop
    wr(`OFF_STAT_C, 32'h0000_004E);
    wr(`OFF_STAT_B, 32'h0000_0010);
    chk(32'(rx_pin_owned_o), 32'h0000_0001);
    node.run({12'hFFF, 1'b0, 8'hC3, 1'b0, 1'b1, 8'h3C, 1'b0}, 32);
    rd(`OFF_STAT_A, rv);
    chk(rv & 32'h0000_009C, 32'h0000_0080);
    rd(`OFF_DATA, rv);
    chk(rv, 32'h0000_003C);
    rd(`OFF_STAT_A, rv);
    chk(rv & 32'h0000_009C, 32'h0000_0090);
    rd(`OFF_DATA, rv);
    chk(rv, 32'h0000_00C3);
    rd(`OFF_STAT_A, rv);
    chk(rv & 32'h0000_0080, 32'h0000_0000);
    $display("receive test done");
    // nine-bit characters both ways, then receiver off flushes
    wr(`OFF_STAT_C, 32'h0000_0047);
    wr(`OFF_STAT_B, 32'h0000_0019);
    wr(`OFF_DATA, 32'h0000_00A5);
    node.run({21'h1F_FFFF, 1'b1, 1'b1, 8'h55, 1'b0}, 32);
    fchk(0, {1'b1, 1'b1, 8'hA5, 1'b0}, 11, nx);
    rd(`OFF_STAT_B, rv);
    chk(rv & 32'h0000_0002, 32'h0000_0002);
    wr(`OFF_STAT_B, 32'h0000_0008);
    chk(32'(rx_pin_owned_o), 32'h0000_0000);
    rd(`OFF_STAT_A, rv);
    chk(rv & 32'h0000_0080, 32'h0000_0000);
    $display("nine-bit test done");
    end_of_test();
  end
endmodule
`default_nettype wire
